//--- fps_pkg.sv
// Overview of operation
// - After fail flag reads 1, host issues read/reset before any other command; code only raises need_reset and still takes any command.
// - Host recovers an aborted buffer program with the full three-cycle reset.
// - Host polls at the last programmed address or inside the erasing block.
// - Each die has its own status word; host finishes one die before the other.
// - First read in status mode exits it; host sends no command before that read.
package fps_pkg;
	// ==========================================================
	// Command addresses and codes
	localparam logic [11:0] FPS_ADDR_UNLOCK1 = 12'h555;
	localparam logic [11:0] FPS_ADDR_UNLOCK2 = 12'h2aa;
	localparam logic [7:0] FPS_CODE_AA = 8'haa;
	localparam logic [7:0] FPS_CODE_55 = 8'h55;
	localparam logic [7:0] FPS_CODE_RESET = 8'hf0;
	localparam logic [7:0] FPS_CODE_RD_STATUS = 8'h70;
	// ==========================================================
	// Status word field positions
	localparam int FPS_SR_READY = 7;
	localparam int FPS_SR_ERS_SUSP = 6;
	localparam int FPS_SR_ERS_ERR = 5;
	localparam int FPS_SR_PGM_ERR = 4;
	localparam int FPS_SR_BUF_ABORT = 3;
	localparam int FPS_SR_PGM_SUSP = 2;
	localparam int FPS_SR_LOCKED = 1;
	// Polling flag positions
	localparam int FPS_DQ_POLL = 7;
	localparam int FPS_DQ_TOGGLE = 6;
	localparam int FPS_DQ_FAIL = 5;
	localparam int FPS_DQ_ERS_TIMER = 3;
	localparam int FPS_DQ_ALT_TOGGLE = 2;
	localparam int FPS_DQ_BUF_ABORT = 1;
	// ==========================================================
	// Bus timing, clock 25 MHz
	localparam int FPS_CLK_NS = 40;
	localparam int FPS_TACC_NS = 110;
	localparam int FPS_TWP_NS = 50;
	localparam int FPS_TACC_CYC = (FPS_TACC_NS + FPS_CLK_NS - 1) / FPS_CLK_NS;
	localparam int FPS_TWP_CYC = (FPS_TWP_NS + FPS_CLK_NS - 1) / FPS_CLK_NS;
	localparam logic [3:0] FPS_CNT_ACC = 4'(FPS_TACC_CYC);
	localparam logic [3:0] FPS_CNT_WP = 4'(FPS_TWP_CYC);
	localparam logic [15:0] FPS_DQ_RESET = 16'h0000;
	localparam logic [7:0] FPS_SR_RESET = 8'h00;
	// ==========================================================
	// User commands
	typedef enum logic [2:0] {
		FPS_CMD_READ,
		FPS_CMD_WRITE,
		FPS_CMD_RD_STATUS,
		FPS_CMD_RESET1,
		FPS_CMD_RESET3,
		FPS_CMD_POLL
	} fps_cmd_t;
	typedef struct packed {
		fps_cmd_t cmd;
		logic die;
		logic [25:0] addr;
		logic [15:0] data;
	} fps_req_t;
	// Decoded status word and polling result
	typedef struct packed {
		logic ready;
		logic erase_suspended;
		logic erase_check_error;
		logic program_error;
		logic buffer_abort;
		logic program_suspended;
		logic locked_attempt;
	} fps_status_t;
	typedef struct packed {
		logic done;
		logic fail;
		logic buffer_abort;
		logic erase_started;
		logic toggling;
	} fps_poll_t;
endpackage : fps_pkg

//--- fps_host.sv
`timescale 1ns/10ps
module fps_host
	import fps_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// User side
	input wire logic req_valid,
	output logic req_ready,
	input wire fps_req_t req,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output fps_status_t rsp_status,
	output fps_poll_t rsp_poll,
	output logic need_reset,
	// Flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_rst_n,
	output logic [26:0] flash_addr,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_i,
	input wire logic flash_ready_busy_in
);
	typedef enum {
		ST_IDLE,
		ST_WR,
		ST_WR_GAP,
		ST_RD,
		ST_RD_GAP,
		ST_DONE
	} fps_st_t;

	fps_st_t st_q;
	fps_req_t req_q;
	logic [3:0] cnt_q;
	logic [1:0] seq_q;
	logic [1:0] rd_idx_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	logic rb_s1_q;
	logic rb_s2_q;
	logic [15:0] first_q;
	logic fail_seen_q;
	logic abort_seen_q;
	logic [15:0] rsp_data_q;
	logic rsp_valid_q;

	// ==========================================================
	// Synchronisers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dq_s1_q <= FPS_DQ_RESET;
			dq_s2_q <= FPS_DQ_RESET;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end else begin
			dq_s1_q <= flash_dq_i;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= flash_ready_busy_in;
			rb_s2_q <= rb_s1_q;
		end
	end

	// Write cycles per command; status command and single-cycle reset are one cycle, three-cycle reset is three
	function automatic logic [1:0] last_seq(input fps_cmd_t c);
		case (c)
			FPS_CMD_RESET3: last_seq = 2'd2;
			default: last_seq = 2'd0;
		endcase
	endfunction

	function automatic logic [26:0] wr_addr(input fps_req_t r, input logic [1:0] s);
		case (r.cmd)
			FPS_CMD_RD_STATUS: wr_addr = {r.die, 14'h0000, FPS_ADDR_UNLOCK1};
			FPS_CMD_RESET3: wr_addr = (s == 2'd1) ? {r.die, 14'h0000, FPS_ADDR_UNLOCK2} :
				{r.die, 14'h0000, FPS_ADDR_UNLOCK1};
			FPS_CMD_RESET1: wr_addr = {r.die, 26'h0000000};
			default: wr_addr = {r.die, r.addr};
		endcase
	endfunction

	function automatic logic [15:0] wr_data(input fps_req_t r, input logic [1:0] s);
		case (r.cmd)
			FPS_CMD_RD_STATUS: wr_data = {8'h00, FPS_CODE_RD_STATUS};
			FPS_CMD_RESET3: wr_data = (s == 2'd0) ? {8'h00, FPS_CODE_AA} :
				(s == 2'd1) ? {8'h00, FPS_CODE_55} : {8'h00, FPS_CODE_RESET};
			FPS_CMD_RESET1: wr_data = {8'h00, FPS_CODE_RESET};
			default: wr_data = r.data;
		endcase
	endfunction

	assign req_ready = (st_q == ST_IDLE);

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			req_q <= '0;
			cnt_q <= 4'h0;
			seq_q <= 2'd0;
			rd_idx_q <= 2'd0;
			first_q <= FPS_DQ_RESET;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (req_valid) begin
						req_q <= req;
						seq_q <= 2'd0;
						rd_idx_q <= 2'd0;
						cnt_q <= FPS_CNT_WP;
						// Status read is a write then the single exiting read
						st_q <= (req.cmd == FPS_CMD_READ || req.cmd == FPS_CMD_POLL) ? ST_RD : ST_WR;
						if (req.cmd == FPS_CMD_READ || req.cmd == FPS_CMD_POLL) begin
							cnt_q <= FPS_CNT_ACC + 4'h2;
						end
					end
				end
				ST_WR: begin
					if (cnt_q == 4'h0) begin
						st_q <= ST_WR_GAP;
						cnt_q <= FPS_CNT_WP;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_WR_GAP: begin
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (seq_q != last_seq(req_q.cmd)) begin
						seq_q <= seq_q + 2'd1;
						cnt_q <= FPS_CNT_WP;
						st_q <= ST_WR;
					end else if (req_q.cmd == FPS_CMD_RD_STATUS) begin
						cnt_q <= FPS_CNT_ACC + 4'h2;
						st_q <= ST_RD;
					end else begin
						st_q <= ST_DONE;
					end
				end
				ST_RD: begin
					if (cnt_q == 4'h0) begin
						// First read is kept so a poll can compare its toggle flag with the second read's
						if (rd_idx_q == 2'd0) begin
							first_q <= dq_s2_q;
						end
						st_q <= ST_RD_GAP;
						cnt_q <= FPS_CNT_WP;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_RD_GAP: begin
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (req_q.cmd == FPS_CMD_POLL && rd_idx_q == 2'd0) begin
						// Second read shows whether the toggle flag moved
						rd_idx_q <= 2'd1;
						cnt_q <= FPS_CNT_ACC + 4'h2;
						st_q <= ST_RD;
					end else begin
						st_q <= ST_DONE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drive
	always_comb begin
		flash_ce_n = !(st_q == ST_WR || st_q == ST_RD);
		flash_we_n = !(st_q == ST_WR);
		flash_oe_n = !(st_q == ST_RD);
		flash_dq_oe = (st_q == ST_WR);
		flash_rst_n = 1'b1;
		flash_addr = (st_q == ST_WR) ? wr_addr(req_q, seq_q) : {req_q.die, req_q.addr};
		flash_dq_o = wr_data(req_q, seq_q);
	end

	// ==========================================================
	// Answers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= FPS_DQ_RESET;
			fail_seen_q <= 1'b0;
			abort_seen_q <= 1'b0;
		end else begin
			rsp_valid_q <= (st_q == ST_DONE);
			if (st_q == ST_RD && cnt_q == 4'h0) begin
				rsp_data_q <= dq_s2_q;
			end
			if (st_q == ST_DONE && req_q.cmd == FPS_CMD_POLL) begin
				if (first_q[FPS_DQ_FAIL]) begin
					fail_seen_q <= 1'b1;
				end
				if (first_q[FPS_DQ_BUF_ABORT]) begin
					abort_seen_q <= 1'b1;
				end
			end
			if (st_q == ST_DONE && req_q.cmd == FPS_CMD_RESET1) begin
				fail_seen_q <= 1'b0;
			end
			if (st_q == ST_DONE && req_q.cmd == FPS_CMD_RESET3) begin
				fail_seen_q <= 1'b0;
				abort_seen_q <= 1'b0;
			end
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign need_reset = fail_seen_q | abort_seen_q;
	assign rsp_status = '{ready: rsp_data_q[FPS_SR_READY],
		erase_suspended: rsp_data_q[FPS_SR_ERS_SUSP] & rsp_data_q[FPS_SR_READY],
		erase_check_error: rsp_data_q[FPS_SR_ERS_ERR] & rsp_data_q[FPS_SR_READY],
		program_error: rsp_data_q[FPS_SR_PGM_ERR] & rsp_data_q[FPS_SR_READY],
		buffer_abort: rsp_data_q[FPS_SR_BUF_ABORT] & rsp_data_q[FPS_SR_READY],
		program_suspended: rsp_data_q[FPS_SR_PGM_SUSP] & rsp_data_q[FPS_SR_READY],
		locked_attempt: rsp_data_q[FPS_SR_LOCKED] & rsp_data_q[FPS_SR_READY]};
	// Done when toggle flag stops moving between two reads and the ready/busy line reads high
	assign rsp_poll = '{done: (first_q[FPS_DQ_TOGGLE] == rsp_data_q[FPS_DQ_TOGGLE]) && !rb_s2_q ? 1'b0 :
			(first_q[FPS_DQ_TOGGLE] == rsp_data_q[FPS_DQ_TOGGLE]),
		fail: rsp_data_q[FPS_DQ_FAIL],
		buffer_abort: rsp_data_q[FPS_DQ_BUF_ABORT],
		erase_started: rsp_data_q[FPS_DQ_ERS_TIMER],
		toggling: first_q[FPS_DQ_TOGGLE] != rsp_data_q[FPS_DQ_TOGGLE]};
endmodule : fps_host

//--- fps_host_props.sv
`timescale 1ns/10ps
module fps_host_props
	import fps_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// User side
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire fps_status_t rsp_status,
	input wire fps_poll_t rsp_poll,
	input wire logic need_reset,
	// Flash pins
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_no_contention: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
		else $error("read strobe overlaps a write");
	chk_write_hold: assert property (!flash_we_n |=> flash_we_n || $stable(flash_dq_o))
		else $error("write data moved under the strobe");
	chk_we_selected: assert property (!flash_we_n |-> !flash_ce_n)
		else $error("write strobe without chip select");
	chk_one_pending: assert property (req_valid && req_ready |=> !req_ready)
		else $error("second request taken while busy");
	chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	chk_answer_bound: assert property (req_valid && req_ready |-> ##[1:300] rsp_valid)
		else $error("no response to a request");
	chk_busy_mask: assert property (!rsp_status.ready |-> rsp_status[5:0] == 6'h00)
		else $error("status bits shown while busy");
	chk_ready_decode: assert property (rsp_status.ready == rsp_data[FPS_SR_READY])
		else $error("ready bit decoded wrongly");
	chk_reset_cause: assert property ($rose(need_reset) |-> rsp_poll.fail || rsp_poll.buffer_abort)
		else $error("reset demand without a failure");
endmodule : fps_host_props

//--- fps_flash_model.sv
`timescale 1ns/10ps
module fps_flash_model
	import fps_pkg::*;
(
	// Flash pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [26:0] addr,
	input wire logic [15:0] din,
	output logic [15:0] dout,
	output logic ready_busy,
	// Operation state set by the bench
	input wire logic busy,
	input wire logic busy_die,
	input wire logic prog,
	input wire logic susp,
	input wire logic fail,
	input wire logic abort,
	input wire logic [7:0] sr_val
);
	logic stat_mode = 1'b0;
	logic tog = 1'b0;
	logic wbit = 1'b0;
	logic [7:0] snap = 8'h00;
	logic [15:0] cur;
	logic [15:0] last = 16'h0000;
	logic polling;
	logic erasing_blk;
	logic die_busy;
	// Block 0 of the busy die is the one under erase
	assign erasing_blk = (addr[25:16] == 10'h000);
	assign die_busy = busy && (addr[26] == busy_die);
	// Outside the erasing block a suspended erase reads as array
	assign polling = die_busy && !(susp && !erasing_blk);
	// Line floats to its pull-up once suspended or failed
	assign ready_busy = !busy || susp || fail || abort;
	always_comb begin
		if (stat_mode)
			cur = {8'h00, snap};
		else if (polling)
			cur = {8'h00, prog ? ~wbit : susp, tog, fail, 1'b0, !prog, 1'b0, abort, 1'b0};
		else
			cur = addr[15:0] ^ 16'h5a5a;
	end
	// Released bus shows the inverse of the last word driven
	assign dout = (!ce_n && !oe_n) ? cur : ~last;
	// Strobes only fall while selected, so chip select is not sampled with them
	always @(negedge oe_n) begin
		if (polling && !stat_mode && !susp)
			tog <= ~tog;
	end
	always @(posedge oe_n) begin
		last <= cur;
		stat_mode <= 1'b0;
	end
	always @(posedge we_n) begin
		if (din[7:0] == FPS_CODE_RD_STATUS) begin
			snap <= {!(die_busy && !susp), sr_val[6:1], 1'b0};
			stat_mode <= 1'b1;
		end else if (die_busy && prog) begin
			wbit <= din[7];
		end
	end
endmodule : fps_flash_model

//--- tb_fps_host.sv
`timescale 1ns/10ps
module tb_fps_host;
	import fps_pkg::*;
	logic clk_sys, rst, req_valid, req_ready, rsp_valid, need_reset;
	logic flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n, flash_dq_oe, flash_ready_busy_in;
	logic busy, busy_die, prog, susp, fail, abort;
	logic [7:0] sr_val;
	logic [15:0] rsp_data, flash_dq_o, flash_dq_i;
	logic [26:0] flash_addr;
	fps_req_t req;
	fps_status_t rsp_status;
	fps_poll_t rsp_poll;
	int errors = 0;
	int comparisons = 0;
	fps_host fps_host_inst (.clk_sys, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data, .rsp_status,
		.rsp_poll, .need_reset, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n, .flash_addr, .flash_dq_o,
		.flash_dq_oe, .flash_dq_i, .flash_ready_busy_in);
	fps_flash_model fps_flash_model_inst (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.addr(flash_addr), .din(flash_dq_o), .dout(flash_dq_i), .ready_busy(flash_ready_busy_in), .busy,
		.busy_die, .prog, .susp, .fail, .abort, .sr_val);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : cmp
	task automatic do_req(input fps_cmd_t cmd, input logic die, input logic [25:0] addr,
		input logic [15:0] data = 16'h0000);
		int n;
		logic taken;
		n = 0;
		taken = 1'b0;
		req = '{cmd: cmd, die: die, addr: addr, data: data};
		req_valid = 1'b1;
		// Offer stands through the edge at which ready was seen high
		do begin
			taken = (req_ready === 1'b1);
			@(posedge clk_sys);
			#2;
			n++;
		end while (!taken && n < 500);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 500) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		if (n >= 500) begin
			errors++;
			stop_test();
		end
		@(posedge clk_sys);
		#2;
	endtask : do_req
	task automatic t_status;
		busy = 1'b0;
		sr_val = 8'h7f;
		do_req(FPS_CMD_RD_STATUS, 1'b0, 26'h0000555);
		cmp("status word", 16'h00fe, rsp_data);
		cmp("status fields", 16'h007f, {9'h000, rsp_status});
		busy = 1'b1;
		do_req(FPS_CMD_RD_STATUS, 1'b0, 26'h0000555);
		cmp("busy status", 16'h0000, {9'h000, rsp_status});
		do_req(FPS_CMD_READ, 1'b0, 26'h0000123);
		cmp("read after status", 16'h0008, rsp_data & 16'hffbf);
	endtask : t_status
	task automatic t_other_die;
		do_req(FPS_CMD_READ, 1'b1, 26'h0000123);
		cmp("other die array", 16'h5b79, rsp_data);
	endtask : t_other_die
	task automatic t_poll;
		do_req(FPS_CMD_POLL, 1'b0, 26'h0000040);
		cmp("toggling", 16'h0001, {15'h0000, rsp_poll.toggling});
		cmp("timer flag", 16'h0001, {15'h0000, rsp_poll.erase_started});
		cmp("busy poll done", 16'h0000, {15'h0000, rsp_poll.done});
		fail = 1'b1;
		do_req(FPS_CMD_POLL, 1'b0, 26'h0000040);
		cmp("reset demand", 16'h0001, {15'h0000, need_reset});
		fail = 1'b0;
		busy = 1'b0;
		do_req(FPS_CMD_RESET1, 1'b0, 26'h0000000);
		cmp("reset demand cleared", 16'h0000, {15'h0000, need_reset});
		busy = 1'b1;
		abort = 1'b1;
		do_req(FPS_CMD_POLL, 1'b0, 26'h0000040);
		cmp("abort seen", 16'h0001, {15'h0000, rsp_poll.buffer_abort});
		abort = 1'b0;
		busy = 1'b0;
		do_req(FPS_CMD_RESET3, 1'b0, 26'h0000000);
		cmp("abort cleared", 16'h0000, {15'h0000, need_reset});
	endtask : t_poll
	task automatic t_suspend;
		busy = 1'b1;
		susp = 1'b1;
		sr_val = 8'h40;
		do_req(FPS_CMD_POLL, 1'b0, 26'h0000040);
		cmp("suspended poll bit", 16'h0080, rsp_data & 16'h0080);
		cmp("suspend done", 16'h0001, {15'h0000, rsp_poll.done});
		do_req(FPS_CMD_READ, 1'b0, 26'h0010123);
		cmp("suspended other block", 16'h5b79, rsp_data);
		do_req(FPS_CMD_RD_STATUS, 1'b0, 26'h0000555);
		cmp("suspend status", 16'h0060, {9'h000, rsp_status});
		susp = 1'b0;
		busy = 1'b0;
	endtask : t_suspend
	task automatic t_program;
		busy = 1'b1;
		prog = 1'b1;
		do_req(FPS_CMD_WRITE, 1'b0, 26'h0000040, 16'h0080);
		do_req(FPS_CMD_READ, 1'b0, 26'h0000040);
		cmp("program poll bit", 16'h0000, rsp_data & 16'hffbf);
		do_req(FPS_CMD_WRITE, 1'b0, 26'h0000041, 16'h0000);
		do_req(FPS_CMD_READ, 1'b0, 26'h0000041);
		cmp("last word poll bit", 16'h0080, rsp_data & 16'hffbf);
		busy = 1'b0;
		prog = 1'b0;
		do_req(FPS_CMD_POLL, 1'b0, 26'h0000041);
		cmp("array after program", 16'h5a1b, rsp_data);
		cmp("program done", 16'h0001, {15'h0000, rsp_poll.done});
	endtask : t_program
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		busy = 1'b0;
		busy_die = 1'b0;
		prog = 1'b0;
		susp = 1'b0;
		fail = 1'b0;
		abort = 1'b0;
		sr_val = 8'h00;
		repeat (3) @(posedge clk_sys);
		#2 rst = 1'b0;
		t_status();
		t_other_die();
		t_poll();
		t_suspend();
		t_program();
		stop_test();
	end
endmodule : tb_fps_host
bind fps_host fps_host_props fps_host_props_inst (.clk_sys, .rst, .req_valid, .req_ready, .rsp_valid, .rsp_data,
	.rsp_status, .rsp_poll, .need_reset, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe);
